/* rtl/lcc_cluster.sv */
// Purpose: cluster of lookup-table logic cells with carry and cascade chains
// Assumes: all inputs synchronous to aclk; cluster clocks act as edge enables
// Notes: clear and preset act at the next aclk edge while the run bit is set, ahead of cluster clocks
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module lcc_cluster
	import lcc_pkg::*;
#(
	parameter int NUM_CELLS = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [lcc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [lcc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] clk_pin,
	input wire logic [lcc_pkg::NUM_LINES-1:0] global_sig,
	input wire logic [lcc_pkg::NUM_LINES-1:0] io_sig,
	input wire logic chip_reset_n,
	input wire logic [4*NUM_CELLS-1:0] cell_data,
	input wire logic carry_in,
	input wire logic cascade_in,
	output logic carry_out,
	output logic cascade_out,
	output logic [NUM_CELLS-1:0] local_out,
	output logic [NUM_CELLS-1:0] row_out
);
	import lcc_pkg::*;

	generate
		if (NUM_CELLS < 1 || NUM_CELLS > MAX_CELLS) begin : g_bad
			$error("NUM_CELLS must lie between 1 and 8");
		end
	endgenerate

	// ****************************************
	// register storage
	// ****************************************
	logic [31:0] ctrl_q;
	logic [31:0] lines_q;
	logic [31:0] cell_cfg_q [NUM_CELLS];
	logic [NUM_CELLS-1:0] q_q;
	logic [NUM_LINES-1:0] line_prev_q;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic aw_got_q;
	logic w_got_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [1:0] bresp_q;
	logic bvalid_q;
	logic rvalid_q;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire [ADDR_W-1:0] wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_got_q ? wdata_q : s_axi_wdata;
	wire [3:0] wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
	wire wr_fire = (aw_got_q || aw_take) && (w_got_q || w_take);
	wire run = ctrl_q[CTRL_RUN];

	// cell index from address; only aligned words inside the window hit
	wire [ADDR_W-1:0] wr_rel = wr_addr - OFF_CELL_BASE;
	wire [ADDR_W-1:0] rd_rel = s_axi_araddr - OFF_CELL_BASE;
	wire wr_cell_hit = wr_addr >= OFF_CELL_BASE && wr_rel[1:0] == 2'h0
		&& int'(wr_rel[ADDR_W-1:2]) < NUM_CELLS;
	wire rd_cell_hit = s_axi_araddr >= OFF_CELL_BASE
		&& rd_rel[1:0] == 2'h0 && int'(rd_rel[ADDR_W-1:2]) < NUM_CELLS;
	wire wr_ctrl = wr_addr == OFF_CTRL;
	wire wr_lines = wr_addr == OFF_LINES;
	wire wr_status = wr_addr == OFF_STATUS;
	wire wr_ok = wr_ctrl || wr_lines || wr_status || wr_cell_hit;
	// configuration is frozen while running; such writes are dropped
	wire cfg_we = wr_fire && !run;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = data[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready = !w_got_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else begin
				aw_got_q <= aw_got_q || aw_take;
				w_got_q <= w_got_q || w_take;
				if (s_axi_bready) begin
					bvalid_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (aw_take) begin
			awaddr_q <= s_axi_awaddr;
		end
		if (w_take) begin
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
	end

	// ****************************************
	// control and configuration registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			lines_q <= LINES_RESET;
		end else begin
			if (wr_fire && wr_ctrl) begin
				ctrl_q <= merge(ctrl_q, wr_data, wr_strb) & CTRL_MASK;
			end
			if (cfg_we && wr_lines) begin
				lines_q <= merge(lines_q, wr_data, wr_strb);
			end
		end
	end

	// ****************************************
	// cluster control lines
	// ****************************************
	logic [NUM_LINES-1:0] line_val;
	logic [NUM_LINES-1:0] line_rise;

	genvar k;
	generate
		for (k = 0; k < NUM_LINES; k++) begin : g_line
			wire [LINE_BITS-1:0] lc = lines_q[LINE_BITS*k +: LINE_BITS];
			wire [2:0] idx = lc[LN_IDX +: 3];
			wire internal = int'(idx) < NUM_CELLS ? local_out[idx] : 1'b1;
			// the last two lines have no dedicated pin; that code stays idle
			wire pin = k < 2 ? clk_pin[k % 2] : 1'b1;
			wire [1:0] src = lc[LN_SRC +: 2];
			wire raw = src == SRC_GLOBAL ? global_sig[k]
				: src == SRC_IO ? io_sig[k]
				: src == SRC_INTERNAL ? internal : pin;
			assign line_val[k] = raw ^ lc[LN_INV];
			assign line_rise[k] = line_val[k] && !line_prev_q[k];
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_prev_q <= '0;
		end else begin
			line_prev_q <= line_val;
		end
	end

	// ****************************************
	// logic cells and chains
	// ****************************************
	logic [NUM_CELLS:0] carry;
	logic [NUM_CELLS:0] casc;
	logic [NUM_CELLS-1:0] q_d;
	logic [NUM_CELLS-1:0] q_we;

	// the fabric wires these ports from the cluster two places lower
	// in the row, so even clusters chain to even and odd to odd
	wire brk = ctrl_q[CTRL_BREAK];
	wire casc_neutral = !cell_cfg_q[0][CF_CASC_OR];
	assign carry[0] = brk ? 1'b0 : carry_in;
	assign casc[0] = brk ? casc_neutral : cascade_in;
	assign carry_out = carry[NUM_CELLS];
	assign cascade_out = casc[NUM_CELLS];

	wire chip_rst = ctrl_q[CTRL_CHIPRST_EN] && !chip_reset_n;

	genvar i;
	generate
		for (i = 0; i < NUM_CELLS; i++) begin : g_cell
			wire [31:0] cf = cell_cfg_q[i];
			wire [3:0] d = cell_data[4*i +: 4];
			wire [15:0] lut = cf[CF_LUT +: 16];
			lcc_mode_type mode;
			lcc_ff_type fft;
			assign mode = lcc_mode_type'(cf[CF_MODE +: 2]);
			assign fft = lcc_ff_type'(cf[CF_FF +: 2]);
			wire cin = carry[i];
			wire counter = mode == LCC_UPDOWN || mode == LCC_CLRCNT;
			wire split = mode != LCC_NORMAL;
			// normal: four inputs, third may be swapped for carry-in
			wire [3:0] idx4 = {d[3], cf[CF_USE_CARRY] ? cin : d[2],
				d[1], d[0]};
			// split modes: low half forms the result, high half the carry
			wire [2:0] idx3 = {cin, counter ? q_q[i] : d[1], d[0]};
			wire f = split ? lut[{1'b0, idx3}] : lut[idx4];
			wire co = lut[{1'b1, idx3}];
			assign carry[i+1] = split ? co : cin;
			// OR is the AND of the inverted terms, inverted again
			wire joined = cf[CF_CASC_OR] ? (f | casc[i])
				: (f & casc[i]);
			// clearable counter spends cascade-in on its synchronous clear
			wire comb = mode == LCC_CLRCNT ? f : joined;
			assign casc[i+1] = comb;

			wire din = cf[CF_PACK] ? d[3] : comb;
			logic ff_next;
			always_comb begin
				unique case (fft)
					LCC_FF_D: ff_next = din;
					LCC_FF_T: ff_next = q_q[i] ^ din;
					LCC_FF_JK: ff_next = (din & !q_q[i]) | (!d[3] & q_q[i]);
					LCC_FF_SR: ff_next = din ? 1'b1 : (d[3] ? 1'b0 : q_q[i]);
				endcase
			end
			wire load_mux = d[2] ? d[3] : comb;
			wire cnt_next = mode == LCC_CLRCNT ? (load_mux & casc[i])
				: load_mux;

			wire ce = cf[CF_CE_EN] ? d[0] : 1'b1;
			wire edge_hit = line_rise[cf[CF_CLK_SEL]];
			wire [1:0] clr_sel = cf[CF_CLR_SEL +: 2];
			wire [1:0] pre_sel = cf[CF_PRE_SEL +: 2];
			// unused clear or preset reads as high, i.e. inactive
			wire clr_n = clr_sel == 2'h1 ? line_val[2]
				: clr_sel == 2'h2 ? line_val[3] : 1'b1;
			wire pre_n = pre_sel == 2'h1 ? line_val[2]
				: pre_sel == 2'h2 ? line_val[3] : 1'b1;

			always_comb begin
				q_we[i] = 1'b1;
				if (chip_rst) begin
					q_d[i] = 1'b0;
				end else if (!clr_n) begin
					q_d[i] = 1'b0;
				end else if (!pre_n) begin
					q_d[i] = 1'b1;
				end else begin
					q_d[i] = counter ? cnt_next : ff_next;
					q_we[i] = edge_hit && ce;
				end
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					q_q[i] <= 1'b0;
				end else if (run && q_we[i]) begin
					q_q[i] <= q_d[i];
				end
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cell_cfg_q[i] <= CELL_RESET;
				end else if (cfg_we && wr_cell_hit
					&& int'(wr_rel[ADDR_W-1:2]) == i) begin
					cell_cfg_q[i] <= merge(cell_cfg_q[i], wr_data, wr_strb);
				end
			end

			// unregistered path is the flip-flop bypass
			assign local_out[i] = cf[CF_LOCAL_REG] ? q_q[i] : comb;
			assign row_out[i] = cf[CF_ROW_REG] ? q_q[i] : comb;
		end
	endgenerate

	// ****************************************
	// read path
	// ****************************************
	logic [31:0] status;
	always_comb begin
		status = '0;
		status[ST_Q +: NUM_CELLS] = q_q;
		status[ST_LOCAL +: NUM_CELLS] = local_out;
		status[ST_ROW +: NUM_CELLS] = row_out;
		status[ST_CARRY] = carry_out;
		status[ST_CASC] = cascade_out;
	end

	wire [2:0] rd_idx = rd_rel[4:2];
	wire rd_ok = s_axi_araddr == OFF_CTRL || s_axi_araddr == OFF_STATUS
		|| s_axi_araddr == OFF_LINES || rd_cell_hit;
	wire [31:0] rd_word = s_axi_araddr == OFF_CTRL ? ctrl_q
		: s_axi_araddr == OFF_STATUS ? status
		: s_axi_araddr == OFF_LINES ? lines_q
		: rd_cell_hit ? cell_cfg_q[rd_idx] : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule // lcc_cluster

`default_nettype wire

/* rtl/lcc_pkg.sv */
// Purpose: shared constants for the logic cell cluster
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: register word offsets are byte addresses
package lcc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_LINES = 8'h08;
	localparam logic [7:0] OFF_CELL_BASE = 8'h10;
	localparam int MAX_CELLS = 8;

	// ****************************************
	// control register fields
	// ****************************************
	localparam int CTRL_RUN = 0;
	localparam int CTRL_BREAK = 1;
	localparam int CTRL_CHIPRST_EN = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0007;

	// ****************************************
	// status register fields
	// ****************************************
	localparam int ST_Q = 0;
	localparam int ST_LOCAL = 8;
	localparam int ST_ROW = 16;
	localparam int ST_CARRY = 24;
	localparam int ST_CASC = 25;

	// ****************************************
	// control line fields, eight bits per line
	// ****************************************
	localparam int NUM_LINES = 4;
	localparam int LINE_BITS = 8;
	localparam int LN_SRC = 0;
	localparam int LN_INV = 2;
	localparam int LN_IDX = 3;
	localparam logic [31:0] LINES_RESET = 32'h0000_0000;
	localparam logic [1:0] SRC_GLOBAL = 2'h0;
	localparam logic [1:0] SRC_IO = 2'h1;
	localparam logic [1:0] SRC_INTERNAL = 2'h2;
	localparam logic [1:0] SRC_CLKPIN = 2'h3;

	// ****************************************
	// cell configuration fields
	// ****************************************
	localparam int CF_LUT = 0;
	localparam int CF_MODE = 16;
	localparam int CF_FF = 18;
	localparam int CF_LOCAL_REG = 20;
	localparam int CF_ROW_REG = 21;
	localparam int CF_CASC_OR = 22;
	localparam int CF_USE_CARRY = 23;
	localparam int CF_PACK = 24;
	localparam int CF_CE_EN = 25;
	localparam int CF_CLK_SEL = 26;
	localparam int CF_CLR_SEL = 27;
	localparam int CF_PRE_SEL = 29;
	localparam logic [31:0] CELL_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		LCC_NORMAL = 2'h0,
		LCC_ARITH = 2'h1,
		LCC_UPDOWN = 2'h3,
		LCC_CLRCNT = 2'h2
	} lcc_mode_type;

	typedef enum logic [1:0] {
		LCC_FF_D = 2'h0,
		LCC_FF_T = 2'h1,
		LCC_FF_JK = 2'h3,
		LCC_FF_SR = 2'h2
	} lcc_ff_type;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* dv/lcc_cluster_sva.sv */
// Purpose: bus handshake checks at the cluster ports
// Assumes: one aclk domain, synchronous active-low reset
// Notes: cell behaviour is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module lcc_cluster_sva
	import lcc_pkg::*;
#(
	parameter int NUM_CELLS = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ****
	// handshakes
	// ****
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_b_follows: assert property (s_wr_take |=> s_axi_bvalid)
		else $error("write answer late");
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	chk_b_drop: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
		else $error("b left early");
	chk_aw_block: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
	chk_r_follows: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	chk_r_drop: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
		else $error("r left early");
	chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken early");
endmodule // lcc_cluster_sva
bind lcc_cluster lcc_cluster_sva #(.NUM_CELLS(NUM_CELLS)) u_sva (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready
);
`default_nettype wire

/* dv/lcc_nbr_cell.sv */
// Purpose: lower neighbour cell feeding the chain inputs
// Assumes: bench sets the neighbour's four data inputs
// Notes: combinational, as a real chain stage is
`timescale 1ns/1ps
`default_nettype none
module lcc_nbr_cell
	import lcc_pkg::*;
(
	input wire logic [3:0] nb_data,
	output logic nb_carry,
	output logic nb_casc
);
	// ****
	// chain outputs
	// ****
	assign nb_carry = (nb_data[0] & nb_data[1])
		| (nb_data[2] & (nb_data[0] | nb_data[1]));
	assign nb_casc = &nb_data;
endmodule // lcc_nbr_cell
`default_nettype wire

/* dv/lcc_cluster_test.sv */
// Purpose: self-checking bench for the cell cluster
// Assumes: master waits for every answer
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module lcc_cluster_test;
	import lcc_pkg::*;
	// ****
	// stimulus and dut
	// ****
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_bvalid, s_axi_rvalid;
	logic s_axi_awready, s_axi_wready, s_axi_arready, carry_in, cascade_in;
	logic carry_out, cascade_out, chip_reset_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr, local_out, row_out;
	logic [31:0] s_axi_wdata, s_axi_rdata, cell_data;
	logic [1:0] s_axi_bresp, s_axi_rresp, clk_pin;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [3:0] s_axi_wstrb, global_sig, io_sig, nb_data;
	int num_errors, checks_done, cycles;
	localparam logic [15:0] LUT_PAT = 16'h2d71;
	lcc_cluster #(.NUM_CELLS(8)) dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .clk_pin, .global_sig, .io_sig,
		.chip_reset_n, .cell_data, .carry_in, .cascade_in, .carry_out,
		.cascade_out, .local_out, .row_out);
	lcc_nbr_cell u_nbr (.nb_data, .nb_carry(carry_in), .nb_casc(cascade_in));
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk(32'(r), 32'(RESP_OKAY));
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rd(OFF_CTRL, d, r);
		chk(d, CTRL_RESET);
		rd(OFF_LINES, d, r);
		chk(d, LINES_RESET);
		rd(OFF_CELL_BASE, d, r);
		chk(d, CELL_RESET);
		rd(8'h0c, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(8'h0c, 32'h1, r);
		chk(32'(r), 32'(RESP_SLVERR));
		put(OFF_CTRL, 32'h1);
		put(OFF_CELL_BASE, 32'hffff);
		rd(OFF_CELL_BASE, d, r);
		chk(d, CELL_RESET);
	endtask
	// chain break must hide the neighbour's carry 1 and cascade 0
	task automatic t_lut();
		nb_data <= 4'h7;
		put(OFF_CTRL, 32'h0);
		put(OFF_CELL_BASE, {16'h0, LUT_PAT});
		put(OFF_CTRL, 32'h3);
		for (int k = 0; k < 16; k++) begin
			cell_data[3:0] <= 4'(k);
			@(posedge aclk);
			chk(32'(local_out[0]), 32'(LUT_PAT[k]));
			chk(32'(row_out[0]), 32'(LUT_PAT[k]));
			chk(32'(carry_out), 32'h0);
		end
	endtask
	// steps: flip-flop kind, d3..d0, expected register
	task automatic t_ff();
		logic [6:0] st [10] = '{7'h07, 7'h01, 7'h02, 7'h27, 7'h26, 7'h77,
			7'h72, 7'h67, 7'h52, 7'h57};
		foreach (st[i]) begin
			put(OFF_CTRL, 32'h0);
			put(OFF_LINES, 32'h3);
			put(OFF_CELL_BASE, {12'h021, st[i][6:5], 2'h0, 16'hcccc});
			put(OFF_CTRL, 32'h3);
			cell_data[3:0] <= st[i][4:1];
			clk_pin <= 2'h1;
			repeat (2) @(posedge aclk);
			clk_pin <= 2'h0;
			chk(32'(local_out[0]), 32'(st[i][0]));
			chk(32'(row_out[0]), 32'(st[i][2]));
		end
	endtask
	// steps: global lines, chip reset, expected register
	task automatic t_clr();
		logic [5:0] st [4] = '{6'h33, 6'h22, 6'h33, 6'h30};
		put(OFF_CTRL, 32'h0);
		put(OFF_LINES, 32'h0400_0003);
		put(OFF_CELL_BASE, 32'h4810_0000);
		put(OFF_CTRL, 32'h5);
		foreach (st[i]) begin
			{global_sig, chip_reset_n} <= st[i][5:1];
			repeat (2) @(posedge aclk);
			chk(32'(local_out[0]), 32'(st[i][0]));
		end
	endtask
	task automatic t_add();
		logic a, b, c;
		put(OFF_CTRL, 32'h0);
		put(OFF_CELL_BASE, 32'h0041_e896);
		put(OFF_CTRL, 32'h1);
		for (int k = 0; k < 8; k++) begin
			{c, b, a} = 3'(k);
			cell_data[1:0] <= {b, a};
			// cascade OR with a low cascade-in leaves the sum alone
			nb_data <= {1'b0, {3{c}}};
			@(posedge aclk);
			chk(32'(local_out[0]), 32'(a ^ b ^ c));
			chk(32'(carry_out), 32'((a & b) | (c & (a | b))));
		end
	endtask
	// steps: neighbour inputs, last cell's inputs, expected cascade
	task automatic t_casc();
		logic [8:0] st [3] = '{9'h1ff, 9'h0fe, 9'h1ee};
		put(OFF_CTRL, 32'h0);
		for (int i = 0; i < 8; i++)
			put(OFF_CELL_BASE + 8'(4 * i), (i == 7) ? 32'h8000 : 32'hffff);
		put(OFF_CTRL, 32'h1);
		foreach (st[i]) begin
			nb_data <= st[i][8:5];
			cell_data <= {st[i][4:1], 28'hfff_ffff};
			@(posedge aclk);
			chk(32'(cascade_out), 32'(st[i][0]));
		end
	endtask
	// steps: neighbour inputs, load value, load, expected register
	task automatic t_cnt();
		logic [6:0] st [4] = '{7'h79, 7'h78, 7'h7f, 7'h00};
		logic [31:0] d;
		logic [1:0] r;
		put(OFF_CTRL, 32'h0);
		put(OFF_CELL_BASE, 32'h0012_c03c);
		put(OFF_CTRL, 32'h1);
		foreach (st[i]) begin
			nb_data <= st[i][6:3];
			cell_data[3:0] <= {st[i][2:1], 2'h0};
			clk_pin <= 2'h1;
			repeat (2) @(posedge aclk);
			clk_pin <= 2'h0;
			chk(32'(local_out[0]), 32'(st[i][0]));
			@(posedge aclk);
		end
		rd(OFF_STATUS, d, r);
		chk(32'(d[ST_Q]), 32'h0);
	endtask
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, chip_reset_n} = 3'h1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00f;
		{cell_data, clk_pin, global_sig} = 38'h4;
		{io_sig, nb_data} = 8'h0;
		{num_errors, checks_done, cycles} = 96'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_lut();
		t_ff();
		t_clr();
		t_add();
		t_casc();
		t_cnt();
		stop_test();
	end
endmodule // lcc_cluster_test
`default_nettype wire
